// ==== verilog/pesg_map.svh ====
// Register offsets, field positions and reset values of the second event group.
// Assumes inclusion by the package and the top module only.
`ifndef PESG_MAP_SVH
`define PESG_MAP_SVH

`define PESG_ADDR_W          6
`define PESG_DATA_W          24
`define PESG_OFS_STATUS      6'h03
`define PESG_OFS_MASK        6'h04
`define PESG_OFS_SENSE       6'h05
`define PESG_OFS_STARTUP     6'h06

`define PESG_STAT_IMPL       24'hC1FFFF
`define PESG_DOM_RTC         24'h000EE3
`define PESG_DOM_OFF         24'h00011C
`define PESG_DOM_SYS         24'hC1F000
`define PESG_STAT_RESET      24'h000080
`define PESG_MASK_RESET      24'hFFF7FF
`define PESG_SENSE_LIVE      24'h40781C

`define PESG_BIT_WDI_RESET   5
`define PESG_BIT_BTN_RESET   6
`define PESG_BIT_USB_BOOT    11
`define PESG_BIT_THERM_LOW   12
`define PESG_BIT_THERM_HIGH  13
`define PESG_BIT_SHORT_TRIP  16
`define PESG_BIT_BATT_REMOVE 22

`define PESG_SU_MODE_LSB     0
`define PESG_SU_MODE_MSB     1
`define PESG_SU_PUMS_LSB     2
`define PESG_SU_PUMS_MSB     5
`define PESG_SU_CHG_PATH     9
`define PESG_SU_WALL_CHG     10

`endif

// ==== verilog/pesg_pkg.sv ====
// Types shared by the second event group block.
// Assumes the constant header is on the include path.
`include "pesg_map.svh"

package pesg_pkg;

  typedef logic [`PESG_DATA_W-1:0] pesg_word_t;

  // Pin-side levels that pass through the two-stage synchroniser.
  typedef struct packed {
    pesg_word_t live;
    logic [1:0] mode;
    logic [3:0] pums;
    logic       chg_path;
    logic       chg_en;
    logic       wall_chg;
  } pesg_pins_t;

  // Register access port of the control interface front end.
  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [`PESG_ADDR_W-1:0] addr;
    pesg_word_t              wdata;
  } pesg_req_t;

  typedef struct packed {
    pesg_word_t status;
    pesg_word_t mask;
    pesg_pins_t sync1;
    pesg_pins_t sync2;
    logic [3:0] pums;
    logic       chg_path;
    logic       chg_en_prev;
    logic       started;
    pesg_word_t rdata;
    logic       irq;
  } pesg_state_t;

endpackage

// ==== verilog/pesg_top.sv ====
// Status, mask and sense registers of the second event group plus startup mode sense.
// Assumes a serial control front end on i_clock presents word reads and writes,
// event pulses come from logic on i_clock, and sense levels come from pins.
`timescale 1ns/1ps
`default_nettype none
`include "pesg_map.svh"

// Behaviour
// [RL1] Bit 5 W1C watchdog reset, power-on domain
// [RL2] Bit 6 W1C button reset, power-on domain
// [RL3] Bit 11 W1C USB boot, power-on only
// [RL4] Bit 12 W1C thermal low, system reset
// [RL5] Bit 13 W1C thermal high, system reset
// [RL6] Bit 16 W1C short trip, system reset
// [RL7] Mask bit 16 RW, resets to 1
// [RL8] Mask bit 11 resets 0, others 1
// [RL9] Mask bit 22 RW, system reset to 1
// [RL10] Sense bit 22 live battery removal, unreset
// [RL11] Sense bit 11 live USB boot, unreset
// [RL12] Startup bit 9 charger path mode, latched
// [RL13] Charger path bit relatched on charger enable
// [RL14] Off-state reset clears off-domain bits
// [RL15] Continuous sense bits track inputs always
// [RL16] Latched sense bits captured once at startup; the charger path bit is also relatched on charger enable
// [RL17] Write one clears; events ignore mask
// [RL18] Interrupt when any unmasked flag set
module pesg_top
  import pesg_pkg::*;
(
  input  wire logic                    i_clock,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_system_reset_n,
  input  wire logic                    i_off_state_reset,
  input  wire logic [`PESG_DATA_W-1:0] i_event,
  input  wire logic [`PESG_DATA_W-1:0] i_sense_live,
  input  wire logic [1:0]              i_mode_pins,
  input  wire logic [3:0]              i_pums_pins,
  input  wire logic                    i_charger_path_mode,
  input  wire logic                    i_charger_enable,
  input  wire logic                    i_wall_charger,
  input  wire logic                    i_reg_wr,
  input  wire logic                    i_reg_rd,
  input  wire logic [`PESG_ADDR_W-1:0] i_reg_addr,
  input  wire logic [`PESG_DATA_W-1:0] i_reg_wdata,
  output logic      [`PESG_DATA_W-1:0] o_reg_rdata,
  output logic                         o_irq
);

  pesg_state_t st_r;
  pesg_state_t st_nxt;
  pesg_pins_t  pins;
  pesg_req_t   req;
  pesg_word_t  clr;
  pesg_word_t  sense_word;
  pesg_word_t  startup_word;

  assign o_reg_rdata = st_r.rdata;
  assign o_irq       = st_r.irq;

  always_comb begin
    pins.live     = i_sense_live;
    pins.mode     = i_mode_pins;
    pins.pums     = i_pums_pins;
    pins.chg_path = i_charger_path_mode;
    pins.chg_en   = i_charger_enable;
    pins.wall_chg = i_wall_charger;
    req.wr        = i_reg_wr;
    req.rd        = i_reg_rd;
    req.addr      = i_reg_addr;
    req.wdata     = i_reg_wdata;
  end

  // Sense words are built from the second synchroniser stage, except the latched startup fields, which come from their holding registers.
  always_comb begin
    sense_word   = st_r.sync2.live & `PESG_SENSE_LIVE; // RL10 RL11 RL15
    startup_word = '0;
    startup_word[`PESG_SU_MODE_MSB:`PESG_SU_MODE_LSB] = st_r.sync2.mode; // RL15
    startup_word[`PESG_SU_PUMS_MSB:`PESG_SU_PUMS_LSB] = st_r.pums; // RL16
    startup_word[`PESG_SU_CHG_PATH] = st_r.chg_path; // RL12
    startup_word[`PESG_SU_WALL_CHG] = st_r.sync2.wall_chg; // RL15
  end

  always_comb begin
    st_nxt = st_r;
    clr    = '0;

    // Synchroniser stages carry no reset so no reset disturbs live sense bits.
    st_nxt.sync1       = pins;
    st_nxt.sync2       = st_r.sync1;
    st_nxt.chg_en_prev = st_r.sync2.chg_en;

    if (!st_r.started) begin
      st_nxt.started  = 1'b1;
      st_nxt.pums     = st_r.sync2.pums; // RL16
      st_nxt.chg_path = st_r.sync2.chg_path; // RL12
    end else if (st_r.sync2.chg_en && !st_r.chg_en_prev) begin
      st_nxt.chg_path = st_r.sync2.chg_path; // RL13
    end

    if (req.wr && req.addr == `PESG_OFS_STATUS) begin
      clr = req.wdata; // RL17
    end
    if (req.wr && req.addr == `PESG_OFS_MASK) begin
      st_nxt.mask = (req.wdata & `PESG_STAT_IMPL)
                  | (~`PESG_STAT_IMPL & `PESG_MASK_RESET); // RL7 RL9
    end

    // A new event wins over a clear in the same cycle; the mask plays no part.
    st_nxt.status = ((st_r.status & ~clr) | i_event) & `PESG_STAT_IMPL; // RL1 RL2 RL3 RL4 RL5 RL6 RL17

    if (!i_system_reset_n) begin
      st_nxt.status = st_nxt.status & ~`PESG_DOM_SYS; // RL4 RL5 RL6
      st_nxt.mask   = (st_nxt.mask & ~`PESG_DOM_SYS)
                    | (`PESG_MASK_RESET & `PESG_DOM_SYS); // RL7 RL9
    end
    if (i_off_state_reset) begin
      st_nxt.status = st_nxt.status & ~`PESG_DOM_OFF; // RL14
      st_nxt.mask   = st_nxt.mask | (`PESG_MASK_RESET & `PESG_DOM_OFF); // RL14
    end

    st_nxt.rdata = st_r.rdata;
    if (req.rd) begin
      case (req.addr)
        `PESG_OFS_STATUS:  st_nxt.rdata = st_r.status;
        `PESG_OFS_MASK:    st_nxt.rdata = st_r.mask;
        `PESG_OFS_SENSE:   st_nxt.rdata = sense_word;
        `PESG_OFS_STARTUP: st_nxt.rdata = startup_word;
        default:           st_nxt.rdata = '0;
      endcase
    end

    st_nxt.irq = |(st_nxt.status & ~st_nxt.mask); // RL18

    // The power-on reset reaches every domain and restarts the startup capture.
    if (i_sys_rst) begin
      st_nxt.status   = `PESG_STAT_RESET; // RL1 RL2 RL3
      st_nxt.mask     = `PESG_MASK_RESET; // RL8
      st_nxt.started  = 1'b0;
      st_nxt.pums     = '0;
      st_nxt.chg_path = 1'b0;
      st_nxt.rdata    = '0;
      st_nxt.irq      = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    st_r <= st_nxt;
  end

endmodule // pesg_top

`default_nettype wire

// ==== verif/pesg_host.sv ====
// Host model that makes word reads and writes.
// Assumes it drives each request 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module pesg_host
  import pesg_pkg::*;
(
  input  wire logic       i_clock,
  output logic            o_wr,
  output logic            o_rd,
  output logic [5:0]      o_addr,
  output var pesg_word_t  o_wdata
);
  initial {o_wr, o_rd, o_addr, o_wdata} = '0;
  task automatic acc(input logic w, input logic [5:0] a, input pesg_word_t d);
    @(posedge i_clock) #1;
    {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
    @(posedge i_clock) #1;
    {o_wr, o_rd} = 2'b00;
  endtask
endmodule // pesg_host
`default_nettype wire

// ==== verif/pesg_top_monitor.sv ====
// Checker on the port of the event group.
// Assumes it is bound to pesg_top.
`timescale 1ns/1ps
`default_nettype none
module pesg_top_monitor
  import pesg_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_sys_rst,
  input wire logic       i_system_reset_n,
  input wire pesg_word_t i_event,
  input wire pesg_word_t i_sense_live,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire pesg_word_t i_reg_wdata,
  input wire pesg_word_t o_reg_rdata,
  input wire logic       o_irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  wire logic rs = i_reg_rd && i_reg_addr == 6'h03;
  wire logic rm = i_reg_rd && i_reg_addr == 6'h04;
  wire logic rn = i_reg_rd && i_reg_addr == 6'h05;
  property p_ev;
    i_event[16] && i_system_reset_n ##1 i_system_reset_n && !i_reg_wr ##1 rs |=> o_reg_rdata[16];
  endproperty
  a_ev: assert property (p_ev) else $error("event flag lost");
  // A clear that meets an event in the same cycle loses, so such cycles are left out.
  property p_clr;
    i_reg_wr && i_reg_addr == 6'h03 && i_reg_wdata[16] && !i_event[16]
      ##1 !i_event[16] ##1 rs |=> !o_reg_rdata[16];
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_irq; $rose(o_irq) |-> $past(|i_event || i_reg_wr); endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_live(int b);
    rn && i_sense_live[b] == $past(i_sense_live[b]) && i_sense_live[b] == $past(i_sense_live[b], 2)
      |=> o_reg_rdata[b] == $past(i_sense_live[b]);
  endproperty
  a_s22: assert property (p_live(22)) else $error("sense 22 wrong");
  a_s11: assert property (p_live(11)) else $error("sense 11 wrong");
  property p_srsv; rn |=> (o_reg_rdata & 24'hBF87E3) == 24'h0; endproperty
  a_srsv: assert property (p_srsv) else $error("sense spare set");
  property p_mrst; !i_system_reset_n ##1 !i_reg_wr ##1 rm |=> o_reg_rdata[16] && o_reg_rdata[22];
  endproperty
  a_mrst: assert property (p_mrst) else $error("mask not reset");
  property p_sclr;
    !i_system_reset_n ##1 i_event == 24'h0 ##1 rs
      |=> o_reg_rdata[16:12] == 5'h00 && o_reg_rdata[23:22] == 2'h0;
  endproperty
  a_sclr: assert property (p_sclr) else $error("status not reset");
  c_irq: cover property (rs && o_irq);
  c_msk: cover property (i_reg_wr && i_reg_addr == 6'h04);
  c_sys: cover property (!i_system_reset_n);
endmodule // pesg_top_monitor
bind pesg_top pesg_top_monitor u_mon (.*);
`default_nettype wire

// ==== verif/tb_pesg_top.sv ====
// Self-checking bench of the event group.
// Assumes the host model owns the register port.
`timescale 1ns/1ps
`default_nettype none
module tb_pesg_top;
  import pesg_pkg::*;
  logic       clk, rst, sysn, offr, cen, path, wr, rd, irq;
  logic [5:0] adr;
  logic [1:0] mode;
  logic [3:0] pums;
  logic       wall;
  pesg_word_t ev, live, wd, rdat;
  int         error_cnt, total_checks;
  logic [29:0] rows[6] = '{{6'h03, 24'h000080}, {6'h04, 24'hFFF7FF}, {6'h05, 24'h400800},
                           {6'h06, 24'h00062A}, {6'h07, 24'h0}, {6'h3F, 24'h0}};
  pesg_top uut (.i_clock(clk), .i_sys_rst(rst), .i_system_reset_n(sysn), .i_off_state_reset(offr),
    .i_event(ev), .i_sense_live(live), .i_mode_pins(mode), .i_pums_pins(pums),
    .i_charger_path_mode(path), .i_charger_enable(cen), .i_wall_charger(wall), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(adr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_irq(irq));
  pesg_host host (.i_clock(clk), .o_wr(wr), .o_rd(rd), .o_addr(adr), .o_wdata(wd));
  task automatic chk(input pesg_word_t g, e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [5:0] a, input pesg_word_t e);
    host.acc(1'b0, a, 24'h0);
    chk(rdat, e);
  endtask
  task automatic pulse(input pesg_word_t b);
    @(posedge clk) #1 ev = b;
    @(posedge clk) #1 ev = '0;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    test_done;
  end
  initial begin
    {rst, sysn, offr, cen, path, ev, live} = {5'b11001, 24'h0, 24'h400800};
    {mode, pums, wall} = {2'h2, 4'hA, 1'b1};
    repeat (5) @(posedge clk);
    #1 rst = 0;
    foreach (rows[i]) rdc(rows[i][29:24], rows[i][23:0]);
    $display("reset table done");
    pulse(24'h013860);
    rdc(6'h03, 24'h0138E0);
    chk({23'h0, irq}, 24'h1);
    @(posedge clk) #1 sysn = 0;
    @(posedge clk) #1 sysn = 1;
    rdc(6'h03, 24'h0008E0);
    host.acc(1'b1, 6'h04, 24'hBEFFFF);
    chk({23'h0, irq}, 24'h0);
    rdc(6'h04, 24'hBEFFFF);
    pulse(24'h010000);
    rdc(6'h03, 24'h0108E0);
    chk({23'h0, irq}, 24'h1);
    host.acc(1'b1, 6'h03, 24'h0);
    rdc(6'h03, 24'h0108E0);
    host.acc(1'b1, 6'h03, 24'h010000);
    chk({23'h0, irq}, 24'h0);
    rdc(6'h03, 24'h0008E0);
    // An event and a clear of the same flag in one cycle: the event wins.
    fork
      pulse(24'h010000);
      host.acc(1'b1, 6'h03, 24'h010000);
    join
    rdc(6'h03, 24'h0108E0);
    chk({23'h0, irq}, 24'h1);
    host.acc(1'b1, 6'h03, 24'h010000);
    $display("flag and mask test done");
    host.acc(1'b1, 6'h04, 24'hBEFEE3);
    pulse(24'h00011C);
    chk({23'h0, irq}, 24'h1);
    @(posedge clk) #1 offr = 1;
    @(posedge clk) #1 offr = 0;
    chk({23'h0, irq}, 24'h0);
    rdc(6'h04, 24'hBEFFFF);
    rdc(6'h03, 24'h0008E0);
    @(posedge clk) #1 sysn = 0;
    @(posedge clk) #1 sysn = 1;
    rdc(6'h04, 24'hFFFFFF);
    $display("reset domain test done");
    @(posedge clk) #1 live = 24'h3FF7FF;
    repeat (3) @(posedge clk);
    rdc(6'h05, 24'h00701C);
    @(posedge clk) #1 {path, mode, pums, wall} = {1'b0, 2'h1, 4'h5, 1'b0};
    repeat (3) @(posedge clk);
    rdc(6'h06, 24'h000229);
    @(posedge clk) #1 cen = 1;
    repeat (4) @(posedge clk);
    rdc(6'h06, 24'h000029);
    $display("sense test done");
    // A second power-on reset in mid-run restarts the startup capture.
    @(posedge clk) #1 rst = 1;
    repeat (3) @(posedge clk);
    #1 rst = 0;
    rdc(6'h03, 24'h000080);
    rdc(6'h04, 24'hFFF7FF);
    rdc(6'h06, 24'h000015);
    $display("startup reset test done");
    test_done;
  end
endmodule // tb_pesg_top
`default_nettype wire
